// File: core/ttm_monitor.sv
// Purpose: multi-domain thermal threshold monitor with register port
// Assumes: converter results arrive from the analog side, asynchronous
// Notes: valid handshake is a toggle, code is held stable around it
`timescale 1ns/1ps
module ttm_monitor
  import ttm_pkg::*;
#(
  parameter logic [TTM_CODE_W-1:0] SHUT_LIMIT = TTM_SHUT_DEF,
  parameter logic [TTM_CODE_W-1:0] SHUT_HYST = TTM_SHUT_HYST_DEF
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // converter side, one toggle and code per domain
  input wire logic [TTM_NUM_DOM-1:0] i_conv_tgl,
  input wire logic [TTM_NUM_DOM*TTM_CODE_W-1:0] i_conv_code,
  // register port
  input wire logic [TTM_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // event and reset outputs
  output logic [TTM_NUM_DOM-1:0] o_hot_evt,
  output logic [TTM_NUM_DOM-1:0] o_cold_evt,
  output logic o_thermal_shutdown_reset
);
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // domain index field sits just above the word offset
  localparam int DOM_LSB = $clog2(TTM_DOM_STRIDE);

  // word within a domain block, one-hot: ack, ctrl, status, threshold
  function automatic logic [3:0] ofs_sel(input logic [TTM_ADDR_W-1:0] a);
    logic [7:0] o;
    o = a & (TTM_DOM_STRIDE - 8'h01);
    if (o == TTM_OFS_THRESH) begin
      ofs_sel = 4'h1;
    end else if (o == TTM_OFS_STATUS) begin
      ofs_sel = 4'h2;
    end else if (o == TTM_OFS_CTRL) begin
      ofs_sel = 4'h4;
    end else if (o == TTM_OFS_ACK) begin
      ofs_sel = 4'h8;
    end else begin
      ofs_sel = 4'h0;
    end
  endfunction : ofs_sel

  logic [TTM_DOM_W-1:0] dom_idx;
  logic dom_ok;
  logic [3:0] sel;
  logic sel_thresh, sel_status, sel_ctrl, sel_ack;

  // domain index and word select; addresses past the last domain select nothing
  assign dom_idx = i_addr[DOM_LSB +: TTM_DOM_W];
  assign dom_ok = (i_addr >> DOM_LSB) < TTM_NUM_DOM;
  assign sel = dom_ok ? ofs_sel(i_addr) : 4'h0;

  // one named select per register word
  assign sel_thresh = sel[0];
  assign sel_status = sel[1];
  assign sel_ctrl = sel[2];
  assign sel_ack = sel[3];

  logic [TTM_CODE_W-1:0] hot_lim_r [TTM_NUM_DOM];
  logic [TTM_CODE_W-1:0] cold_lim_r [TTM_NUM_DOM];
  logic [1:0] ctl_r [TTM_NUM_DOM];
  logic [TTM_CODE_W-1:0] code_w [TTM_NUM_DOM];
  logic [TTM_NUM_DOM-1:0] hot_w, cold_w, shut_w;
  logic [31:0] rdata_r;
  logic [TTM_NUM_DOM-1:0] hot_o_r, cold_o_r;
  logic shut_o_r;

  // ----------------------------------------
  // per-domain sync and compare
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < TTM_NUM_DOM; g++) begin : g_dom
      logic [2:0] tgl_r;
      logic [TTM_CODE_W-1:0] c1_r, c2_r;
      logic vld;
      logic wr_me, wr_thresh, wr_ctrl, ack_h, ack_c;

      // new result when the synced toggle changes; writes aimed at this domain
      assign vld = tgl_r[2] ^ tgl_r[1];
      assign wr_me = i_wr && (dom_idx == TTM_DOM_W'(g));
      assign wr_thresh = wr_me && sel_thresh;
      assign wr_ctrl = wr_me && sel_ctrl;
      assign ack_h = wr_me && sel_ack && i_wdata[TTM_ST_HOT_BIT];
      assign ack_c = wr_me && sel_ack && i_wdata[TTM_ST_COLD_BIT];

      // two-stage sync of the toggle, third stage for its edge
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          tgl_r <= '0;
        end else begin
          tgl_r <= {tgl_r[1:0], i_conv_tgl[g]};
        end
      end

      // two-stage sync of the code, settled before the toggle edge is seen
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          c1_r <= '0;
          c2_r <= '0;
        end else begin
          c1_r <= i_conv_code[g*TTM_CODE_W +: TTM_CODE_W];
          c2_r <= c1_r;
        end
      end

      // software settings
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          hot_lim_r[g] <= TTM_HOT_RST;
          cold_lim_r[g] <= TTM_COLD_RST;
          ctl_r[g] <= TTM_CTL_RST;
        end else if (wr_thresh) begin
          hot_lim_r[g] <= i_wdata[TTM_HOT_LSB +: TTM_CODE_W];
          cold_lim_r[g] <= i_wdata[TTM_COLD_LSB +: TTM_CODE_W];
        end else if (wr_ctrl) begin
          ctl_r[g] <= {i_wdata[TTM_CTL_COLD_EN], i_wdata[TTM_CTL_HOT_EN]};
        end
      end

      ttm_domain u_dom (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_valid(vld),
        .i_code(c2_r),
        .i_hot_lim(hot_lim_r[g]),
        .i_cold_lim(cold_lim_r[g]),
        .i_shut_lim(SHUT_LIMIT),
        .i_shut_hyst(SHUT_HYST),
        .i_hot_en(ctl_r[g][TTM_CTL_HOT_EN]),
        .i_cold_en(ctl_r[g][TTM_CTL_COLD_EN]),
        .i_ack_hot(ack_h),
        .i_ack_cold(ack_c),
        .o_code(code_w[g]),
        .o_hot(hot_w[g]),
        .o_cold(cold_w[g]),
        .o_shut(shut_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  logic [31:0] rd_nxt;
  // read mux; ack word and unmapped words read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (sel_thresh) begin
      rd_nxt[TTM_HOT_LSB +: TTM_CODE_W] = hot_lim_r[dom_idx];
      rd_nxt[TTM_COLD_LSB +: TTM_CODE_W] = cold_lim_r[dom_idx];
    end else if (sel_status) begin
      rd_nxt[TTM_ST_CODE_LSB +: TTM_CODE_W] = code_w[dom_idx];
      rd_nxt[TTM_ST_HOT_BIT] = hot_w[dom_idx];
      rd_nxt[TTM_ST_COLD_BIT] = cold_w[dom_idx];
      rd_nxt[TTM_ST_SHUT_BIT] = shut_w[dom_idx];
    end else if (sel_ctrl) begin
      rd_nxt[TTM_CTL_HOT_EN] = ctl_r[dom_idx][TTM_CTL_HOT_EN];
      rd_nxt[TTM_CTL_COLD_EN] = ctl_r[dom_idx][TTM_CTL_COLD_EN];
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= i_rd ? rd_nxt : 32'h0000_0000;
    end
  end

  // pending hot events, one per domain
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hot_o_r <= '0;
    end else begin
      hot_o_r <= hot_w;
    end
  end

  // pending cold events, one per domain
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cold_o_r <= '0;
    end else begin
      cold_o_r <= cold_w;
    end
  end

  // shutdown reset while any domain holds its shutdown state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shut_o_r <= 1'b0;
    end else begin
      shut_o_r <= |shut_w;
    end
  end

  assign o_rdata = rdata_r;
  assign o_hot_evt = hot_o_r;
  assign o_cold_evt = cold_o_r;
  assign o_thermal_shutdown_reset = shut_o_r;
endmodule : ttm_monitor

// File: common/ttm_pkg.sv
// Purpose: shared constants for the thermal threshold monitor
// Assumes: 32-bit register port, word-aligned offsets chosen locally
// Notes: codes are 10-bit, larger code means hotter
package ttm_pkg;
  localparam int TTM_CODE_W = 10;
  localparam int TTM_NUM_DOM = 2;
  localparam int TTM_DOM_W = 1;
  localparam int TTM_ADDR_W = 8;
  // register byte offsets, one block of four words per domain
  localparam logic [7:0] TTM_DOM_STRIDE = 8'h10;
  localparam logic [7:0] TTM_OFS_THRESH = 8'h00; // temperature_threshold_per_domain
  localparam logic [7:0] TTM_OFS_STATUS = 8'h04; // current code and pending events
  localparam logic [7:0] TTM_OFS_CTRL = 8'h08;   // event enables
  localparam logic [7:0] TTM_OFS_ACK = 8'h0C;    // write one to clear events
  // threshold register fields
  localparam int TTM_HOT_LSB = 16;  // upper_limit_field [25:16]
  localparam int TTM_COLD_LSB = 0;  // lower_limit_field [9:0]
  // status register fields
  localparam int TTM_ST_CODE_LSB = 0;
  localparam int TTM_ST_HOT_BIT = 16;
  localparam int TTM_ST_COLD_BIT = 17;
  localparam int TTM_ST_SHUT_BIT = 18;
  // control register fields
  localparam int TTM_CTL_HOT_EN = 0;
  localparam int TTM_CTL_COLD_EN = 1;
  // reset values
  localparam logic [9:0] TTM_HOT_RST = 10'h3C0;
  localparam logic [9:0] TTM_COLD_RST = 10'h000;
  localparam logic [1:0] TTM_CTL_RST = 2'h1;
  // fused shutdown limit and release hysteresis defaults
  localparam logic [9:0] TTM_SHUT_DEF = 10'h3F0;
  localparam logic [9:0] TTM_SHUT_HYST_DEF = 10'h020;
endpackage : ttm_pkg

// File: core/ttm_domain.sv
// Purpose: comparisons and event flags for one voltage domain
// Assumes: code input already synchronised and qualified by a valid pulse
// Notes: flag set wins over acknowledge in the same cycle
`timescale 1ns/1ps
module ttm_domain
  import ttm_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // conversion result
  input wire logic i_valid,
  input wire logic [TTM_CODE_W-1:0] i_code,
  // settings
  input wire logic [TTM_CODE_W-1:0] i_hot_lim,
  input wire logic [TTM_CODE_W-1:0] i_cold_lim,
  input wire logic [TTM_CODE_W-1:0] i_shut_lim,
  input wire logic [TTM_CODE_W-1:0] i_shut_hyst,
  input wire logic i_hot_en,
  input wire logic i_cold_en,
  input wire logic i_ack_hot,
  input wire logic i_ack_cold,
  // state
  output logic [TTM_CODE_W-1:0] o_code,
  output logic o_hot,
  output logic o_cold,
  output logic o_shut
);
  logic [TTM_CODE_W-1:0] code_r;
  logic hot_r, cold_r, shut_r;
  logic hot_hit, cold_hit, shut_hit, shut_clear;
  logic [TTM_CODE_W:0] rel_lim;

  // compare each new result
  assign hot_hit = i_valid && i_hot_en && (i_code > i_hot_lim);
  assign cold_hit = i_valid && i_cold_en && (i_code < i_cold_lim);
  assign shut_hit = i_valid && (i_code > i_shut_lim);
  assign rel_lim = {1'b0, i_shut_lim} - {1'b0, i_shut_hyst};
  assign shut_clear = i_valid && !rel_lim[TTM_CODE_W] && (i_code < rel_lim[TTM_CODE_W-1:0]);

  // sticky flags, set beats acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      code_r <= '0;
      hot_r <= 1'b0;
      cold_r <= 1'b0;
      shut_r <= 1'b0;
    end else begin
      if (i_valid) code_r <= i_code;
      hot_r <= hot_hit | (hot_r & ~i_ack_hot);
      cold_r <= cold_hit | (cold_r & ~i_ack_cold);
      if (shut_hit) shut_r <= 1'b1;
      else if (shut_clear) shut_r <= 1'b0;
    end
  end

  assign o_code = code_r;
  assign o_hot = hot_r;
  assign o_cold = cold_r;
  assign o_shut = shut_r;
endmodule : ttm_domain

// File: dv/ttm_monitor_properties.sv
// Purpose: port checks for the thermal monitor
// Assumes: codes held stable around each toggle
// Notes: cause window is eight cycles of toggle history
`timescale 1ns/1ps
module ttm_monitor_chk
  import ttm_pkg::*;
#(
  parameter logic [TTM_CODE_W-1:0] SHUT_LIMIT = TTM_SHUT_DEF,
  parameter logic [TTM_CODE_W-1:0] SHUT_HYST = TTM_SHUT_HYST_DEF
)(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [TTM_NUM_DOM-1:0] i_conv_tgl,
  input wire logic [TTM_NUM_DOM*TTM_CODE_W-1:0] i_conv_code,
  input wire logic [TTM_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [TTM_NUM_DOM-1:0] o_hot_evt,
  input wire logic [TTM_NUM_DOM-1:0] o_cold_evt,
  input wire logic o_thermal_shutdown_reset
);
  logic [1:0] tgl_r;
  logic [7:0] h0_r;
  logic [7:0] h1_r;
  wire [1:0] tchg = i_conv_tgl ^ tgl_r;
  wire ack_h0 = i_wr && i_addr == TTM_OFS_ACK && i_wdata[TTM_ST_HOT_BIT];
  wire ack_c0 = i_wr && i_addr == TTM_OFS_ACK && i_wdata[TTM_ST_COLD_BIT];
  // recent toggle changes per domain
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tgl_r <= 2'h0;
      h0_r <= 8'h00;
      h1_r <= 8'h00;
    end else begin
      tgl_r <= i_conv_tgl;
      h0_r <= {h0_r[6:0], tchg[0]};
      h1_r <= {h1_r[6:0], tchg[1]};
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  unmap_read_a: assert property (i_rd && i_addr >= 8'h20 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  hot_hold_a: assert property ($fell(o_hot_evt[0]) |-> $past(ack_h0) || $past(ack_h0, 2) || $past(ack_h0, 3))
    else $error("hot flag dropped without ack");
  cold_hold_a: assert property ($fell(o_cold_evt[0]) |-> $past(ack_c0) || $past(ack_c0, 2) || $past(ack_c0, 3))
    else $error("cold flag dropped without ack");
  hot_cause_a: assert property ($rose(o_hot_evt[0]) |-> |h0_r)
    else $error("hot flag without new result");
  cold_cause_a: assert property ($rose(o_cold_evt[0]) |-> |h0_r)
    else $error("cold flag without new result");
  dom_cause_a: assert property ($rose(o_hot_evt[1]) |-> |h1_r)
    else $error("second domain flag without its result");
  shut_rise_a: assert property (tchg[0] && i_conv_code[9:0] > SHUT_LIMIT |-> ##[1:8] o_thermal_shutdown_reset)
    else $error("shutdown not raised");
  shut_hold_a: assert property ($fell(o_thermal_shutdown_reset) |->
    i_conv_code[9:0] <= SHUT_LIMIT && i_conv_code[19:10] <= SHUT_LIMIT)
    else $error("shutdown released while hot");
endmodule : ttm_monitor_chk
bind ttm_monitor ttm_monitor_chk #(.SHUT_LIMIT(SHUT_LIMIT), .SHUT_HYST(SHUT_HYST)) chk (.i_sys_clk, .i_rstn,
  .i_conv_tgl, .i_conv_code, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_hot_evt, .o_cold_evt,
  .o_thermal_shutdown_reset);

// File: dv/ttm_monitor_tb.sv
// Purpose: directed register and conversion tests
// Assumes: default shutdown limit, release below limit minus hysteresis
// Notes: codes are held well around every toggle
`timescale 1ns/1ps
module ttm_monitor_tb
  import ttm_pkg::*;
;
  logic i_sys_clk = 0;
  logic i_rstn = 0;
  logic i_wr = 0;
  logic i_rd = 0;
  logic [1:0] i_conv_tgl = 2'h0;
  logic [19:0] i_conv_code = 20'h0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata;
  logic [1:0] o_hot_evt;
  logic [1:0] o_cold_evt;
  logic o_thermal_shutdown_reset;
  int fail_count = 0;
  int checks = 0;
  ttm_monitor DUT (.i_sys_clk, .i_rstn, .i_conv_tgl, .i_conv_code, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_hot_evt, .o_cold_evt, .o_thermal_shutdown_reset);
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, got);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(nm, e, o_rdata);
  endtask : rd
  // new code, then toggle, then let the flags settle
  task automatic conv(input int d, input logic [9:0] c);
    @(posedge i_sys_clk);
    i_conv_code[d*10 +: 10] <= c;
    repeat (3) @(posedge i_sys_clk);
    i_conv_tgl[d] <= ~i_conv_tgl[d];
    repeat (8) @(posedge i_sys_clk);
    #1;
  endtask : conv
  task automatic ev(input logic [4:0] e);
    chk("events", {27'h0, e}, {27'h0, o_thermal_shutdown_reset, o_cold_evt, o_hot_evt});
  endtask : ev
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd(8'h00, 32'h03C0_0000, "thresh0");
    rd(8'h08, 32'h1, "ctrl0");
    rd(8'h10, 32'h03C0_0000, "thresh1");
    rd(8'h24, 32'h0, "unmapped");
    $display("test reset done");
    // hot flag, held until ack, strict compare
    wr(8'h00, 32'h0200_0000);
    conv(0, 10'h201);
    ev(5'h01);
    rd(8'h04, 32'h0001_0201, "status0");
    conv(0, 10'h200);
    ev(5'h01);
    wr(8'h0C, 32'h0001_0000);
    conv(0, 10'h200);
    ev(5'h00);
    $display("test hot done");
    // cold flag only while enabled
    wr(8'h00, 32'h0200_0100);
    wr(8'h08, 32'h3);
    conv(0, 10'h0FF);
    ev(5'h04);
    wr(8'h0C, 32'h0002_0000);
    wr(8'h08, 32'h1);
    conv(0, 10'h0FF);
    ev(5'h00);
    $display("test cold done");
    // second domain on its own
    wr(8'h10, 32'h0100_0000);
    conv(1, 10'h150);
    ev(5'h02);
    rd(8'h14, 32'h0001_0150, "status1");
    wr(8'h1C, 32'h0001_0000);
    $display("test domain done");
    // shutdown raise, hold inside hysteresis, release below it
    conv(0, 10'h3F1);
    ev(5'h11);
    rd(8'h04, 32'h0005_03F1, "status0");
    conv(0, 10'h3D0);
    ev(5'h11);
    conv(0, 10'h3CF);
    ev(5'h01);
    $display("test shutdown done");
    // handler moves hot limit above the code, then cools with cold enabled
    wr(8'h0C, 32'h0001_0000);
    wr(8'h00, 32'h03DF_0100); // hot limit moved to code plus step
    conv(0, 10'h3DF);
    ev(5'h00); // equal code is not above the limit
    conv(0, 10'h3E0);
    ev(5'h01);
    wr(8'h0C, 32'h0001_0000);
    wr(8'h00, 32'h03FF_03C0);
    wr(8'h08, 32'h3); // cold enabled only while cooling
    rd(8'h08, 32'h3, "ctrl0");
    conv(0, 10'h3C0);
    ev(5'h00); // equal code is not below the limit
    conv(0, 10'h3BF);
    ev(5'h04);
    rd(8'h0C, 32'h0, "ack0");
    wr(8'h0C, 32'h0002_0000);
    wr(8'h08, 32'h1); // cold disabled again after cooling
    $display("test tracking done");
    // shutdown raised and released by the second domain alone
    conv(1, 10'h3F5);
    ev(5'h12);
    conv(1, 10'h150);
    ev(5'h02);
    $display("test domain shutdown done");
    complete_run();
  end
endmodule : ttm_monitor_tb
